// >>> src/motor_pkg.sv
// shared constants and types for the sine phase timing and protection block
package motor_pkg;

	// ==================== clock and timing
	localparam int          CLK_MHZ            = 50;
	localparam int          REFRESH_US         = 1500;
	localparam int          REFRESH_CYCLES_DFLT = REFRESH_US * CLK_MHZ;
	localparam int          ROT_WINDOW_MS      = 167;
	localparam int          ROT_WINDOW_DFLT    = ROT_WINDOW_MS * CLK_MHZ * 1000;
	localparam int          ONE_HZ_MS          = 1000;
	localparam int          ONE_HZ_DFLT        = ONE_HZ_MS * CLK_MHZ * 1000;

	// ==================== carrier and modulation
	localparam logic [8:0]  CARRIER_LAST       = 9'h1FF;
	localparam logic [8:0]  LAST_TICK_60       = 9'h03F;
	localparam logic [8:0]  LAST_TICK_360      = 9'h17F;
	localparam logic [25:0] TICKS_360          = 26'h0000180;
	localparam int          TICK_SHIFT_60      = 6;
	localparam logic [9:0]  CYCLE_TICKS        = 10'h180;
	localparam logic [9:0]  PHASE_120          = 10'h080;
	localparam logic [9:0]  PHASE_240          = 10'h100;
	localparam logic [8:0]  SINE_HALF          = 9'h0C0;
	localparam logic [21:0] SINE_PEAK_SQ       = 22'h002400;
	localparam logic [21:0] SINE_GAIN          = 22'h00007F;
	localparam logic [7:0]  SINE_MID           = 8'h80;

	// ==================== lead correction
	localparam logic [5:0]  LEAD_FIRST_STEP    = 6'h08;
	localparam logic [5:0]  LEAD_SAT_STEP      = 6'h27;
	localparam logic [8:0]  LEAD_MAX_TICKS     = 9'h020;

	// ==================== lock detection
	localparam logic [11:0] LOCK_DRIVE_COUNTS  = 12'h1F4;
	localparam logic [11:0] LOCK_STOP_COUNTS   = 12'hBB8;

	// ==================== register map
	localparam logic [7:0]  REG_CTRL           = 8'h00;
	localparam logic [7:0]  REG_STATUS         = 8'h04;
	localparam logic [7:0]  REG_SEG_PERIOD     = 8'h08;
	localparam logic [7:0]  REG_REV_PERIOD     = 8'h0C;
	localparam logic [7:0]  REG_LEAD           = 8'h10;
	localparam int          CTRL_MODE360_BIT   = 0;
	localparam int          CTRL_DIR_BIT       = 1;
	localparam int          CTRL_AMP_LSB       = 8;
	localparam logic [7:0]  AMP_RESET          = 8'h80;

	// ==================== drive sequencing
	typedef enum logic [1:0] {
		ST_WAIT,
		ST_REFRESH,
		ST_RUN,
		ST_LOCK_STOP
	} drive_state_t;

endpackage : motor_pkg

// >>> src/sine_phase_timing_and_protection.sv
// hall timed sine pwm generator with fault, lock and refresh sequencing
//
// Functional notes
// - lead level maps to 0..30 degree offset
// - 60 mode: edge to edge interval sets segment
// - segment split into 64 equal ticks
// - late edge: elapsing period times next segment
// - 60 mode restarts on every accepted hall edge
// - 360 mode: U falling period, 384 ticks
// - 360 mode restarts only on U falling
// - sine overcurrent blocks all six, carrier release
// - square overcurrent blocks highs only, carrier release
// - low fault input blocks, clears at carrier
// - high fault input blocks, clears at carrier
// - stop mode restart: command then refresh
// - rotating restart: command only, no refresh
// - counters and rotation pulse run during fault
// - invalid or open hall blocks all six gate outputs
// - sine drive ignores out of sequence hall
// - undervoltage blocks, then command and refresh
// - no rotation by drive end blocks commutation
// - lock: 500 drive, 3000 stop, refresh
// - two ordered edges within window mean rotating
// - low speed command resets lock state
// - open timer holds lock, grounded disables it
// - triangle carrier at clock over 512
// - square drive when slow or reversed
`timescale 1ns/1ps

module sine_phase_timing_and_protection #(
	parameter int unsigned REFRESH_CYCLES = motor_pkg::REFRESH_CYCLES_DFLT,
	parameter int unsigned ROT_WINDOW     = motor_pkg::ROT_WINDOW_DFLT,
	parameter int unsigned ONE_HZ_CYCLES  = motor_pkg::ONE_HZ_DFLT
) (
	// clock, reset, enable
	input  logic        hclk,
	input  logic        hresetn,
	input  logic        clk_en,
	// ahb-lite slave
	input  logic        hsel,
	input  logic [31:0] haddr,
	input  logic [1:0]  htrans,
	input  logic        hwrite,
	input  logic [2:0]  hsize,
	input  logic [31:0] hwdata,
	input  logic        hready,
	output logic        hreadyout,
	output logic        hresp,
	output logic [31:0] hrdata,
	// hall comparator levels
	input  logic        phase_u_hall,
	input  logic        phase_v_hall,
	input  logic        phase_w_hall,
	input  logic        hall_inputs_open,
	// protection and command
	input  logic        current_sense_input,
	input  logic        fault_stop_active_low,
	input  logic        fault_stop_active_high,
	input  logic        undervoltage,
	input  logic        speed_command_above,
	input  logic [5:0]  lead_correction_level,
	// lock timer
	input  logic        lock_timer_count,
	input  logic        lock_timer_cap_pin_open,
	input  logic        lock_timer_cap_pin_grounded,
	// gate drive
	output logic        u_high_side_out,
	output logic        v_high_side_out,
	output logic        w_high_side_out,
	output logic        u_low_side_out,
	output logic        v_low_side_out,
	output logic        w_low_side_out,
	output logic        rotation_pulse_out
);

	// ==================== derived counts
	localparam logic [25:0] ONE_HZ_C     = 26'(ONE_HZ_CYCLES);
	localparam logic [23:0] ROT_WIN_C    = 24'(ROT_WINDOW);
	localparam logic [16:0] REFRESH_LAST = 17'(REFRESH_CYCLES - 1);

	// ==================== state
	typedef struct packed {
		logic [2:0]                hall;
		logic [25:0]               seg_cnt;
		logic [25:0]               seg_len;
		logic [25:0]               rev_cnt;
		logic [25:0]               rev_len;
		logic [25:0]               tick_div;
		logic [8:0]                tick_idx;
		logic [8:0]                carrier;
		logic                      oc;
		logic                      fault;
		logic                      need_refresh;
		motor_pkg::drive_state_t   st;
		logic [16:0]               rest_cnt;
		logic [11:0]               lock_cnt;
		logic                      rotating;
		logic                      had_edge;
		logic                      dir_fwd;
		logic [23:0]               gap_cnt;
		logic [5:0]                lead;
		logic                      mode360;
		logic                      dir_rev;
		logic [7:0]                amp;
		logic                      wr_pend;
		logic [7:0]                wr_addr;
		logic [31:0]               hrdata;
		logic                      hreadyout;
		logic                      hresp;
		logic [2:0]                hi;
		logic [2:0]                lo;
		logic                      fg;
	} state_t;

	localparam state_t RESET_Q = '{
		st:        motor_pkg::ST_WAIT,
		amp:       motor_pkg::AMP_RESET,
		hreadyout: 1'b1,
		dir_fwd:   1'b1,
		default:   '0
	};

	state_t q;
	state_t n;

	// ==================== functions
	// forward hall order 100,110,010,011,001,101; 7 marks an illegal code
	function automatic logic [2:0] sector(input logic [2:0] h);
		case (h)
			3'h4:    return 3'h0;
			3'h6:    return 3'h1;
			3'h2:    return 3'h2;
			3'h3:    return 3'h3;
			3'h1:    return 3'h4;
			3'h5:    return 3'h5;
			default: return 3'h7;
		endcase
	endfunction : sector

	function automatic logic [2:0] next_sector(input logic [2:0] s);
		return (s == 3'h5) ? 3'h0 : 3'(s + 3'h1);
	endfunction : next_sector

	function automatic logic [8:0] wrap_phase(input logic [9:0] x);
		return (x >= motor_pkg::CYCLE_TICKS) ? 9'(x - motor_pkg::CYCLE_TICKS) : x[8:0];
	endfunction : wrap_phase

	function automatic logic [8:0] lead_ticks(input logic [5:0] step);
		if (step < motor_pkg::LEAD_FIRST_STEP)
			return 9'h000;
		if (step >= motor_pkg::LEAD_SAT_STEP)
			return motor_pkg::LEAD_MAX_TICKS;
		return 9'(step - 6'h07);
	endfunction : lead_ticks

	// parabolic half waves: cheap and close enough to a sine for fan drive
	function automatic logic [7:0] sine_level(input logic [8:0] ph, input logic [7:0] amp);
		logic        upper;
		logic [8:0]  x;
		logic [21:0] p;
		logic [6:0]  y;
		logic [14:0] ys;
		upper = (ph >= motor_pkg::SINE_HALF);
		x     = upper ? 9'(ph - motor_pkg::SINE_HALF) : ph;
		p     = 22'(x) * 22'(9'(motor_pkg::SINE_HALF - x));
		y     = 7'((p * motor_pkg::SINE_GAIN) / motor_pkg::SINE_PEAK_SQ);
		ys    = 15'(y) * 15'(amp);
		return upper ? 8'(motor_pkg::SINE_MID - 8'(ys >> 8))
		             : 8'(motor_pkg::SINE_MID + 8'(ys >> 8));
	endfunction : sine_level

	// {high u,v,w, low u,v,w} for 120 degree square drive
	function automatic logic [5:0] square_pattern(input logic [2:0] s, input logic rev);
		logic [5:0] pat;
		case (s)
			3'h0:    pat = 6'b100_010;
			3'h1:    pat = 6'b100_001;
			3'h2:    pat = 6'b010_001;
			3'h3:    pat = 6'b010_100;
			3'h4:    pat = 6'b001_100;
			3'h5:    pat = 6'b001_010;
			default: pat = 6'b000_000;
		endcase
		return rev ? {pat[2:0], pat[5:3]} : pat;
	endfunction : square_pattern

	// ==================== hall decode
	logic [2:0] hall_in;
	logic [2:0] s_in;
	logic [2:0] s_q;
	logic       adv_f;
	logic       adv_r;
	logic       hall_bad;
	logic       slow;
	logic       square_mode;
	logic       accept;
	logic       u_fall;
	logic       restart;

	assign hall_in     = {phase_u_hall, phase_v_hall, phase_w_hall};
	assign s_in        = sector(hall_in);
	assign s_q         = sector(q.hall);
	assign adv_f       = (s_q != 3'h7) && (s_in == next_sector(s_q));
	assign adv_r       = (s_in != 3'h7) && (s_q == next_sector(s_in));
	assign hall_bad    = (s_in == 3'h7) || hall_inputs_open;
	assign slow        = (q.rev_len >= ONE_HZ_C) || (q.rev_cnt >= ONE_HZ_C);
	assign square_mode = slow || (q.dir_fwd == q.dir_rev);
	// sine drive only takes a neighbouring code, so a glitch cannot jump sectors
	assign accept      = !hall_bad && (hall_in != q.hall)
	                     && (square_mode || adv_f || adv_r || (s_q == 3'h7));
	assign u_fall      = accept && q.hall[2] && !hall_in[2];
	assign restart     = q.mode360 ? u_fall : accept;

	// ==================== modulation timing
	logic [25:0] tick_len;
	logic [8:0]  last_tick;
	logic [8:0]  base;
	logic [8:0]  ph_u;
	logic [8:0]  ph_v;
	logic [8:0]  ph_w;
	logic [7:0]  carrier_tri;
	logic        boundary;

	assign tick_len  = q.mode360 ? (q.rev_len / motor_pkg::TICKS_360)
	                             : (q.seg_len >> motor_pkg::TICK_SHIFT_60);
	assign last_tick = q.mode360 ? motor_pkg::LAST_TICK_360 : motor_pkg::LAST_TICK_60;
	assign base      = q.mode360 ? q.tick_idx : 9'({s_q, 6'h00} + 9'(q.tick_idx));
	assign ph_u      = wrap_phase(10'(base) + 10'(lead_ticks(q.lead)));
	assign ph_v      = wrap_phase(10'(ph_u) + (q.dir_rev ? motor_pkg::PHASE_240
	                                                     : motor_pkg::PHASE_120));
	assign ph_w      = wrap_phase(10'(ph_u) + (q.dir_rev ? motor_pkg::PHASE_120
	                                                     : motor_pkg::PHASE_240));
	assign carrier_tri = q.carrier[8] ? ~q.carrier[7:0] : q.carrier[7:0];
	assign boundary  = (q.carrier == motor_pkg::CARRIER_LAST);

	// ==================== next state
	logic        fault_in;
	logic        block;
	logic [5:0]  pat;
	logic [31:0] rdata;
	logic        addr_ok;

	assign fault_in = !fault_stop_active_low || fault_stop_active_high;
	assign block    = hall_bad || q.fault || undervoltage;
	assign pat      = square_pattern(s_q, q.dir_rev);
	assign addr_ok  = hsel && hready && htrans[1];

	always_comb begin
		n     = q;
		rdata = 32'h00000000;

		// carrier and current limit
		n.carrier = 9'(q.carrier + 9'h001);
		n.oc      = current_sense_input || (q.oc && !boundary);
		n.fault   = fault_in || (q.fault && !boundary);
		n.lead    = lead_correction_level;
		n.fg      = q.hall[2];

		// interval measurement, saturating so a stall never wraps
		if (accept) begin
			n.hall     = hall_in;
			n.dir_fwd  = adv_f;
			n.seg_len  = q.seg_cnt;
			n.seg_cnt  = 26'h0000001;
		end else if (q.seg_cnt != 26'h3FFFFFF) begin
			n.seg_cnt  = 26'(q.seg_cnt + 26'h0000001);
		end
		if (u_fall) begin
			n.rev_len  = q.rev_cnt;
			n.rev_cnt  = 26'h0000001;
		end else if (q.rev_cnt != 26'h3FFFFFF) begin
			n.rev_cnt  = 26'(q.rev_cnt + 26'h0000001);
		end

		// tick generator; the index parks on its last tick until the edge comes
		if (restart) begin
			n.tick_div = 26'h0000000;
			n.tick_idx = 9'h000;
		end else if (26'(q.tick_div + 26'h0000001) >= tick_len) begin
			n.tick_div = 26'h0000000;
			if (q.tick_idx < last_tick)
				n.tick_idx = 9'(q.tick_idx + 9'h001);
		end else begin
			n.tick_div = 26'(q.tick_div + 26'h0000001);
		end

		// rotation detection
		if (accept) begin
			if (q.had_edge && (adv_f || adv_r) && (adv_f == q.dir_fwd)
			    && (q.gap_cnt < ROT_WIN_C))
				n.rotating = 1'b1;
			n.had_edge = 1'b1;
			n.gap_cnt  = 24'h000000;
		end else if (q.gap_cnt < ROT_WIN_C) begin
			n.gap_cnt  = 24'(q.gap_cnt + 24'h000001);
		end else begin
			n.rotating = 1'b0;
			n.had_edge = 1'b0;
		end

		// drive sequencing
		unique case (q.st)
			motor_pkg::ST_WAIT: begin
				n.rest_cnt = 17'h00000;
				if (speed_command_above && !q.fault && !undervoltage)
					n.st = (q.need_refresh || slow) ? motor_pkg::ST_REFRESH
					                                : motor_pkg::ST_RUN;
			end
			motor_pkg::ST_REFRESH: begin
				n.rest_cnt = 17'(q.rest_cnt + 17'h00001);
				if (q.rest_cnt == REFRESH_LAST) begin
					n.st           = motor_pkg::ST_RUN;
					n.need_refresh = 1'b0;
				end
			end
			motor_pkg::ST_RUN: begin
				if (q.rotating || lock_timer_cap_pin_grounded) begin
					n.lock_cnt = 12'h000;
				end else if (lock_timer_count) begin
					n.lock_cnt = 12'(q.lock_cnt + 12'h001);
					if (q.lock_cnt == 12'(motor_pkg::LOCK_DRIVE_COUNTS - 12'h001)) begin
						n.st       = motor_pkg::ST_LOCK_STOP;
						n.lock_cnt = 12'h000;
					end
				end
			end
			motor_pkg::ST_LOCK_STOP: begin
				if (lock_timer_count && !lock_timer_cap_pin_open) begin
					n.lock_cnt = 12'(q.lock_cnt + 12'h001);
					if (q.lock_cnt == 12'(motor_pkg::LOCK_STOP_COUNTS - 12'h001)) begin
						n.st       = motor_pkg::ST_REFRESH;
						n.lock_cnt = 12'h000;
						n.rest_cnt = 17'h00000;
					end
				end
			end
		endcase

		// lock state clears on a low command even while a fault or undervoltage holds
		if (!speed_command_above) begin
			n.lock_cnt     = 12'h000;
			n.rotating     = 1'b0;
			n.had_edge     = 1'b0;
		end

		// overriding conditions, strongest first
		if (undervoltage) begin
			n.st           = motor_pkg::ST_WAIT;
			n.need_refresh = 1'b1;
		end else if (q.fault || fault_in) begin
			n.st           = motor_pkg::ST_WAIT;
		end else if (!speed_command_above) begin
			n.st           = motor_pkg::ST_WAIT;
		end else if (lock_timer_cap_pin_open && q.st != motor_pkg::ST_WAIT) begin
			n.st           = motor_pkg::ST_LOCK_STOP;
		end

		// gate outputs
		n.hi = 3'b000;
		n.lo = 3'b000;
		if (block) begin
			n.hi = 3'b000;
			n.lo = 3'b000;
		end else if (q.st == motor_pkg::ST_REFRESH) begin
			n.lo = 3'b111;
		end else if (q.st == motor_pkg::ST_RUN) begin
			if (square_mode) begin
				n.hi = (q.oc || (q.amp <= carrier_tri)) ? 3'b000 : pat[5:3];
				n.lo = pat[2:0];
			end else if (!q.oc) begin
				n.hi = {sine_level(ph_u, q.amp) > carrier_tri,
				        sine_level(ph_v, q.amp) > carrier_tri,
				        sine_level(ph_w, q.amp) > carrier_tri};
				n.lo = ~n.hi;
			end
		end

		// bus: writes land in the data phase, reads are fetched in the address phase
		n.wr_pend = addr_ok && hwrite;
		n.wr_addr = haddr[7:0];
		if (q.wr_pend) begin
			case (q.wr_addr)
				motor_pkg::REG_CTRL: begin
					n.mode360 = hwdata[motor_pkg::CTRL_MODE360_BIT];
					n.dir_rev = hwdata[motor_pkg::CTRL_DIR_BIT];
					n.amp     = hwdata[motor_pkg::CTRL_AMP_LSB +: 8];
				end
				default: ;
			endcase
		end
		case (haddr[7:0])
			motor_pkg::REG_CTRL:
				rdata = {16'h0000, q.amp, 6'h00, q.dir_rev, q.mode360};
			motor_pkg::REG_STATUS:
				rdata = {22'h000000, q.dir_fwd, hall_bad, square_mode, slow,
				         q.rotating, q.fault, q.oc, q.need_refresh, q.st};
			motor_pkg::REG_SEG_PERIOD:
				rdata = {6'h00, q.seg_len};
			motor_pkg::REG_REV_PERIOD:
				rdata = {6'h00, q.rev_len};
			motor_pkg::REG_LEAD:
				rdata = {23'h000000, lead_ticks(q.lead)};
			default:
				rdata = 32'h00000000;
		endcase
		n.hrdata    = (addr_ok && !hwrite) ? rdata : 32'h00000000;
		n.hreadyout = 1'b1;
		n.hresp     = 1'b0;
	end

	// ==================== registers
	// the bus freezes with the enable too; masters must not start transfers then
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			q <= RESET_Q;
		else if (clk_en)
			q <= n;
	end

	assign hreadyout          = q.hreadyout;
	assign hresp              = q.hresp;
	assign hrdata             = q.hrdata;
	assign u_high_side_out    = q.hi[2];
	assign v_high_side_out    = q.hi[1];
	assign w_high_side_out    = q.hi[0];
	assign u_low_side_out     = q.lo[2];
	assign v_low_side_out     = q.lo[1];
	assign w_low_side_out     = q.lo[0];
	assign rotation_pulse_out = q.fg;

	// ==================== checks
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_oc_sine_block: assert property (
		(clk_en && q.oc && q.st == motor_pkg::ST_RUN && !square_mode)
		|=> (q.hi == 3'b000) && (q.lo == 3'b000))
		else $error("sine overcurrent did not block all outputs");

	a_oc_square_high: assert property (
		(clk_en && q.oc && !block && q.st == motor_pkg::ST_RUN && square_mode)
		|=> (q.hi == 3'b000) && (q.lo == $past(pat[2:0])))
		else $error("square overcurrent did not block only high side");

	a_oc_release: assert property (
		(clk_en && q.oc && boundary && !current_sense_input) |=> !q.oc)
		else $error("current limit not released at carrier end");

	a_fault_low_block: assert property (
		(clk_en && !fault_stop_active_low) ##1 clk_en
		|=> (q.hi == 3'b000) && (q.lo == 3'b000) && (q.st == motor_pkg::ST_WAIT))
		else $error("low fault input did not stop commutation");

	a_fault_high_block: assert property (
		(clk_en && fault_stop_active_high) ##1 clk_en
		|=> (q.hi == 3'b000) && (q.lo == 3'b000) && q.fault)
		else $error("high fault input did not stop commutation");

	a_hall_bad_block: assert property (
		(clk_en && hall_bad) |=> (q.hi == 3'b000) && (q.lo == 3'b000))
		else $error("invalid hall code left outputs driving");

	a_refresh_len: assert property (
		(q.st == motor_pkg::ST_RUN && $past(q.st) == motor_pkg::ST_REFRESH)
		|-> $past(q.rest_cnt) == REFRESH_LAST)
		else $error("refresh ended early");

	a_lock_drive_end: assert property (
		(q.st == motor_pkg::ST_LOCK_STOP && $past(q.st) == motor_pkg::ST_RUN
		 && !$past(lock_timer_cap_pin_open))
		|-> $past(q.lock_cnt) == 12'(motor_pkg::LOCK_DRIVE_COUNTS - 12'h001))
		else $error("lock stop entered before drive period end");

	a_cmd_release: assert property (
		(clk_en && !speed_command_above)
		|=> (q.st == motor_pkg::ST_WAIT) && !q.rotating && (q.lock_cnt == 12'h000))
		else $error("low speed command did not clear lock state");

endmodule : sine_phase_timing_and_protection

// >>> verif/hall_model.sv
// hall sensor model: forward six-step pattern, one edge per period
`timescale 1ns/1ps
module hall_model (
	// clock
	input  logic        hclk,
	// control
	input  logic        run,
	input  logic [15:0] period,
	// hall levels, bit 0 is phase u
	output logic [2:0]  hall
);
	// ==================== step sequence
	// levels move only on a step, so a stalled rotor keeps its last code
	localparam logic [2:0] SEQ [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
	int unsigned step_ff = 0;
	int unsigned cnt_ff  = 0;
	assign hall = SEQ[step_ff];
	always @(posedge hclk) begin
		if (run && cnt_ff + 1 >= period) begin
			cnt_ff  <= 0;
			step_ff <= (step_ff == 5) ? 0 : step_ff + 1;
		end else if (run) begin
			cnt_ff <= cnt_ff + 1;
		end
	end
endmodule : hall_model

// >>> verif/sine_phase_timing_and_protection_test.sv
// bench for the sine phase timing and protection block
`timescale 1ns/1ps
module sine_phase_timing_and_protection_test;
	// ==================== signals
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
	logic [1:0]  htrans = 2'h0;
	logic        hready, hresp, fg, hforce = 1'b0, hopen = 1'b0;
	logic        run = 1'b0, cmd = 1'b0, ltc = 1'b0, oc = 1'b0, en = 1'b1;
	logic        tpo = 1'b0, tpg = 1'b0;
	logic [15:0] period = 16'h0064;
	logic [2:0]  hall, hin, flt = 3'h0, hfix = 3'h0;
	logic [5:0]  lead = 6'h00, gates;
	int          failures = 0, samples_checked = 0;
	assign hin = hforce ? hfix : hall;
	always #10 hclk = ~hclk;
	hall_model hall_u (.hclk(hclk), .run(run), .period(period), .hall(hall));
	sine_phase_timing_and_protection #(.REFRESH_CYCLES(20), .ROT_WINDOW(2000),
		.ONE_HZ_CYCLES(5000)) dut_u (
		.hclk(hclk), .hresetn(hresetn), .clk_en(en), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .phase_u_hall(hin[0]),
		.phase_v_hall(hin[1]), .phase_w_hall(hin[2]), .hall_inputs_open(hopen),
		.current_sense_input(oc), .fault_stop_active_low(~flt[0]),
		.fault_stop_active_high(flt[1]), .undervoltage(flt[2]), .speed_command_above(cmd),
		.lead_correction_level(lead), .lock_timer_count(ltc), .lock_timer_cap_pin_open(tpo),
		.lock_timer_cap_pin_grounded(tpg), .u_high_side_out(gates[5]),
		.v_high_side_out(gates[4]), .w_high_side_out(gates[3]), .u_low_side_out(gates[2]),
		.v_low_side_out(gates[1]), .w_low_side_out(gates[0]), .rotation_pulse_out(fg));
	// ==================== shared tasks
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask : cyc
	// one single transfer; read data lands in d
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (!hready) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (!hready) @(posedge hclk);
		d = hrdata;
		chk("hresp", {31'h0, hresp}, 32'h0);
	endtask : xfer
	task automatic state_is(input logic [1:0] s);
		xfer(motor_pkg::REG_STATUS, 1'b0, 32'h0);
		chk("state", {30'h0, d[1:0]}, {30'h0, s});
	endtask : state_is
	task automatic pulse(input int n);
		repeat (n) begin
			ltc <= 1'b1;
			@(posedge hclk);
			ltc <= 1'b0;
			@(posedge hclk);
		end
	endtask : pulse
	// ==================== scenarios
	task automatic t_start;
		chk("reset gates", {26'h0, gates}, 32'h0);
		xfer(motor_pkg::REG_CTRL, 1'b0, 32'h0);
		chk("ctrl", d, {16'h0, motor_pkg::AMP_RESET, 8'h00});
		xfer(8'h40, 1'b0, 32'h0);
		chk("unmapped", d, 32'h0);
		cyc(5200);
		cmd <= 1'b1;
		cyc(4);
		chk("refresh gates", {26'h0, gates}, 32'h7);
		cyc(40);
		state_is(2'h2);
		chk("slow square", {30'h0, d[7:6]}, 32'h3);
		oc <= 1'b1;
		cyc(3);
		chk("oc highs", {29'h0, gates[5:3]}, 32'h0);
		chk("oc lows", {31'h0, gates[2:0] != 3'h0}, 32'h1);
		oc <= 1'b0;
		$display("test start done");
	endtask : t_start
	task automatic t_lead;
		logic [5:0] s [6] = '{6'h00, 6'h07, 6'h08, 6'h26, 6'h27, 6'h3F};
		logic [8:0] e [6] = '{9'h000, 9'h000, 9'h001, 9'h01F, 9'h020, 9'h020};
		for (int i = 0; i < 6; i++) begin
			lead <= s[i];
			cyc(2);
			xfer(motor_pkg::REG_LEAD, 1'b0, 32'h0);
			chk("lead ticks", d, {23'h0, e[i]});
		end
		$display("test lead done");
	endtask : t_lead
	task automatic t_guard;
		logic [3:0] c [3] = '{4'h0, 4'h7, 4'h9};
		for (int i = 0; i < 3; i++) begin
			hforce <= 1'b1;
			{hopen, hfix} <= c[i];
			cyc(3);
			chk("bad hall gates", {26'h0, gates}, 32'h0);
			hforce <= 1'b0;
			hopen <= 1'b0;
			cyc(3);
			chk("hall resume", {31'h0, gates !== 6'h00}, 32'h1);
		end
		for (int i = 0; i < 3; i++) begin
			flt <= 3'(1 << i);
			cyc(3);
			chk("fault gates", {26'h0, gates}, 32'h0);
			flt <= 3'h0;
			cyc(600);
			state_is(2'h2);
		end
		$display("test guard done");
	endtask : t_guard
	task automatic t_lock;
		pulse(499);
		state_is(2'h2);
		pulse(1);
		cyc(2);
		chk("lock gates", {26'h0, gates}, 32'h0);
		state_is(2'h3);
		pulse(2999);
		state_is(2'h3);
		pulse(1);
		state_is(2'h1);
		cyc(30);
		// frozen enable: pulses must not count
		en <= 1'b0;
		pulse(600);
		en <= 1'b1;
		state_is(2'h2);
		tpg <= 1'b1;
		pulse(500);
		state_is(2'h2);
		tpg <= 1'b0;
		pulse(500);
		cmd <= 1'b0;
		cyc(3);
		state_is(2'h0);
		cmd <= 1'b1;
		cyc(3);
		state_is(2'h1);
		cyc(30);
		tpo <= 1'b1;
		cyc(3);
		state_is(2'h3);
		chk("open gates", {26'h0, gates}, 32'h0);
		tpo <= 1'b0;
		cmd <= 1'b0;
		cyc(2);
		cmd <= 1'b1;
		$display("test lock done");
	endtask : t_lock
	task automatic t_spin;
		logic f;
		int   k;
		run <= 1'b1;
		xfer(motor_pkg::REG_CTRL, 1'b1, 32'h00008001);
		xfer(motor_pkg::REG_CTRL, 1'b0, 32'h0);
		chk("ctrl write", d, 32'h00008001);
		cyc(1300);
		xfer(motor_pkg::REG_SEG_PERIOD, 1'b0, 32'h0);
		chk("segment", d, 32'h00000064);
		xfer(motor_pkg::REG_REV_PERIOD, 1'b0, 32'h0);
		chk("revolution", d, 32'h00000258);
		state_is(2'h2);
		chk("fast", {31'h0, d[6]}, 32'h0);
		oc <= 1'b1;
		cyc(3);
		chk("oc sine gates", {26'h0, gates}, 32'h0);
		oc <= 1'b0;
		cyc(600);
		chk("oc released", {31'h0, gates != 6'h00}, 32'h1);
		flt <= 3'h1;
		cyc(5);
		f = fg;
		cyc(300);
		chk("pulse in fault", {31'h0, f ^ fg}, 32'h1);
		flt <= 3'h0;
		// poll every two cycles, so a refresh of twenty cycles would show
		d = 32'h0;
		for (k = 0; k < 400 && d[1:0] == 2'h0; k++)
			xfer(motor_pkg::REG_STATUS, 1'b0, 32'h0);
		chk("no refresh", {30'h0, d[1:0]}, 32'h2);
		$display("test spin done");
	endtask : t_spin
	// ==================== run control
	task automatic report_and_stop;
		$display("compared %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_start();
		t_lead();
		t_guard();
		t_lock();
		t_spin();
		report_and_stop();
	end
	initial begin
		#1000000;
		failures++;
		report_and_stop();
	end
endmodule : sine_phase_timing_and_protection_test
